// File: rtl/rfpg_map.svh
// register offsets, field positions, reset values and set points for the
// regulator fault / power-good mask / rail control register bank.
// assumes: included by rtl/rfpg_pkg.sv and the bank module by bare name.
`ifndef RFPG_MAP_SVH
`define RFPG_MAP_SVH

// register offsets
`define RFPG_OFS_FAULT_A      8'h16
`define RFPG_OFS_FAULT_B      8'h17
`define RFPG_OFS_PG_MASK_A    8'h18
`define RFPG_OFS_PG_MASK_B    8'h19
`define RFPG_OFS_IO_CTRL      8'h30
`define RFPG_OFS_CORE_CTRL    8'h31

// reset values
`define RFPG_RST_FAULT_A      8'h00
`define RFPG_RST_FAULT_B      8'h00
`define RFPG_RST_PG_MASK_A    8'h00
`define RFPG_RST_PG_MASK_B    8'h00
`define RFPG_RST_IO_CTRL      8'h1a
`define RFPG_RST_CORE_CTRL    8'h4a
`define RFPG_RST_UNMAPPED     8'h00

// widths of the live parts of the two narrow registers
`define RFPG_FAULT_B_W        2
`define RFPG_PG_MASK_B_W      4

// io rail control fields
`define RFPG_IO_DECAY_BIT     6
`define RFPG_IO_MODE_HI       1
`define RFPG_IO_MODE_LO       0
`define RFPG_IO_FIXED_MASK    8'hbc
`define RFPG_IO_FIXED_VAL     8'h18

// core rail control fields
`define RFPG_CORE_LP_HI       7
`define RFPG_CORE_LP_LO       6
`define RFPG_CORE_VSEL_HI     5
`define RFPG_CORE_VSEL_LO     4
`define RFPG_CORE_EXIT_HI     3
`define RFPG_CORE_EXIT_LO     2
`define RFPG_CORE_MODE_HI     1
`define RFPG_CORE_MODE_LO     0
`define RFPG_CORE_RST_LP      2'h1
`define RFPG_CORE_RST_VSEL    2'h0
`define RFPG_CORE_RST_EXIT    2'h2
`define RFPG_CORE_RST_MODE    2'h2

// mode field codes
`define RFPG_MODE_CODE_OFF    2'h0
`define RFPG_MODE_CODE_FORCED 2'h3
`define RFPG_EXIT_CODE_KEEP   2'h0
`define RFPG_LP_CODE_NONE     2'h0

// core rail voltages in millivolts
`define RFPG_MV_W             10
`define RFPG_VSEL0_MV         10'd950
`define RFPG_VSEL1_MV         10'd900
`define RFPG_VSEL2_MV         10'd850
`define RFPG_VSEL3_MV         10'd800
`define RFPG_LP1_MV           10'd750
`define RFPG_LP2_MV           10'd800
`define RFPG_LP3_MV           10'd850

`endif

// File: rtl/rfpg_pkg.sv
// types shared by the register bank: the register access request,
// the decoded converter mode and the rail request bundles.
// assumes: rfpg_map.svh is on the include path.
package rfpg_pkg;

`include "rfpg_map.svh"

    // one register access from the serial front end
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rfpg_req_t;

    // decoded converter operating mode
    typedef enum logic [1:0] {
        RFPG_MODE_OFF,
        RFPG_MODE_AUTO,
        RFPG_MODE_FORCED
    } rfpg_mode_t;

    // what the bank asks of the io rail
    typedef struct packed {
        rfpg_mode_t mode;
        logic       decay;
    } rfpg_io_req_t;

    // what the bank asks of the primary core rail
    typedef struct packed {
        rfpg_mode_t                  mode;
        logic [`RFPG_MV_W-1:0]       target_mv;
    } rfpg_core_req_t;

endpackage : rfpg_pkg

// File: rtl/rfpg_regs.sv
// regulator fault flags, power-good masks and io / core rail control.
// assumes: a serial front end presents one-cycle register requests on
// clk_in; fault, power-good and sleep pins are asynchronous levels.
`timescale 1ns/1ps
`include "rfpg_map.svh"

module rfpg_regs
    import rfpg_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rstn_in,
    input  wire logic                  sys_rstn_in,
    input  wire rfpg_req_t             req_in,
    input  wire logic [7:0]            fault_a_in,
    input  wire logic [1:0]            fault_b_in,
    input  wire logic [7:0]            pg_a_in,
    input  wire logic [3:0]            pg_b_in,
    input  wire logic                  host_sleep_n_in,
    output logic      [7:0]            rdata_out,
    output logic                       pg_combined_out,
    output rfpg_io_req_t               io_req_out,
    output rfpg_core_req_t             core_req_out
);

    localparam int PIN_W = 8 + `RFPG_FAULT_B_W + 8 + `RFPG_PG_MASK_B_W + 1;
    localparam logic [PIN_W-1:0] PIN_RST = {{(PIN_W-1){1'b0}}, 1'b1};
    // reset words held as constants so their fields can be sliced
    localparam logic [7:0] FAULT_B_RST = `RFPG_RST_FAULT_B;
    localparam logic [7:0] MASK_B_RST  = `RFPG_RST_PG_MASK_B;
    localparam logic [7:0] IO_RST      = `RFPG_RST_IO_CTRL;

    // decoding helpers

    // mode field decode shared by both rails
    function automatic rfpg_mode_t mode_of(input logic [1:0] code);
        rfpg_mode_t m;
        m = RFPG_MODE_AUTO;
        if (code == `RFPG_MODE_CODE_OFF) begin
            m = RFPG_MODE_OFF;
        end else if (code == `RFPG_MODE_CODE_FORCED) begin
            m = RFPG_MODE_FORCED;
        end
        return m;
    endfunction : mode_of

    // register write strobe for one offset
    function automatic logic wr_hit(input rfpg_req_t r,
                                    input logic [7:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction : wr_hit

    // input synchronisers

    logic [PIN_W-1:0]              pins_raw;
    logic [PIN_W-1:0]              pins_sync;
    logic [7:0]                    fault_a_sync;
    logic [`RFPG_FAULT_B_W-1:0]    fault_b_sync;
    logic [7:0]                    pg_a_sync;
    logic [`RFPG_PG_MASK_B_W-1:0]  pg_b_sync;
    logic                          sleep_n_sync;

    // all pins share one bank of stages; sleep resets high (awake)
    assign pins_raw = {fault_a_in, fault_b_in, pg_a_in, pg_b_in,
                       host_sleep_n_in};

    rfpg_sync #(
        .W       (PIN_W),
        .RST_VAL (PIN_RST)
    ) u_sync (
        .clk_in   (clk_in),
        .rstn_in  (rstn_in),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    // split the synchronised vector back into its groups
    assign fault_a_sync = pins_sync[PIN_W-1 -: 8];
    assign fault_b_sync = pins_sync[PIN_W-9 -: `RFPG_FAULT_B_W];
    assign pg_a_sync    = pins_sync[`RFPG_PG_MASK_B_W + 8 -: 8];
    assign pg_b_sync    = pins_sync[`RFPG_PG_MASK_B_W -: `RFPG_PG_MASK_B_W];
    assign sleep_n_sync = pins_sync[0];

    // write strobes

    logic wr_fault_a;
    logic wr_fault_b;
    logic wr_mask_a;
    logic wr_mask_b;
    logic wr_io;
    logic wr_core;

    assign wr_fault_a = wr_hit(req_in, `RFPG_OFS_FAULT_A);
    assign wr_fault_b = wr_hit(req_in, `RFPG_OFS_FAULT_B);
    assign wr_mask_a  = wr_hit(req_in, `RFPG_OFS_PG_MASK_A);
    assign wr_mask_b  = wr_hit(req_in, `RFPG_OFS_PG_MASK_B);
    assign wr_io      = wr_hit(req_in, `RFPG_OFS_IO_CTRL);
    assign wr_core    = wr_hit(req_in, `RFPG_OFS_CORE_CTRL);

    // sticky fault flags, always-on domain

    logic [7:0]                   fault_a_ff;
    logic [`RFPG_FAULT_B_W-1:0]   fault_b_ff;
    logic [7:0]                   nxt_fault_a;
    logic [`RFPG_FAULT_B_W-1:0]   nxt_fault_b;
    logic [7:0]                   keep_a;
    logic [`RFPG_FAULT_B_W-1:0]   keep_b;

    // a written zero clears, a written one leaves the flag alone
    assign keep_a = wr_fault_a ? req_in.wdata : 8'hff;
    assign keep_b = wr_fault_b ? req_in.wdata[`RFPG_FAULT_B_W-1:0]
                               : {`RFPG_FAULT_B_W{1'b1}};

    // a fault in the clearing cycle survives: set wins over clear
    assign nxt_fault_a = (fault_a_ff & keep_a) | fault_a_sync;
    assign nxt_fault_b = (fault_b_ff & keep_b) | fault_b_sync;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_a_ff <= `RFPG_RST_FAULT_A;
            fault_b_ff <= FAULT_B_RST[`RFPG_FAULT_B_W-1:0];
        end else begin
            fault_a_ff <= nxt_fault_a;
            fault_b_ff <= nxt_fault_b;
        end
    end

    // power-good masks, always-on domain

    logic [7:0]                    mask_a_ff;
    logic [`RFPG_PG_MASK_B_W-1:0]  mask_b_ff;

    // upper bits of mask b are reserved and never stored
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mask_a_ff <= `RFPG_RST_PG_MASK_A;
            mask_b_ff <= MASK_B_RST[`RFPG_PG_MASK_B_W-1:0];
        end else begin
            if (wr_mask_a) begin
                mask_a_ff <= req_in.wdata;
            end
            if (wr_mask_b) begin
                mask_b_ff <= req_in.wdata[`RFPG_PG_MASK_B_W-1:0];
            end
        end
    end

    // combined power-good tree

    logic [7:0]                    pg_a_forced;
    logic [`RFPG_PG_MASK_B_W-1:0]  pg_b_forced;
    logic                          nxt_pg_combined;
    logic                          pg_combined_ff;

    // a masked input counts as good and drops out of the tree
    assign pg_a_forced     = pg_a_sync | mask_a_ff;
    assign pg_b_forced     = pg_b_sync | mask_b_ff;
    assign nxt_pg_combined = (&pg_a_forced) & (&pg_b_forced);

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pg_combined_ff <= 1'b0;
        end else begin
            pg_combined_ff <= nxt_pg_combined;
        end
    end

    // sleep edge detect, always-on domain

    logic sleep_n_q_ff;
    logic asleep;
    logic sleep_exit;

    // previous level resets high so a quiet pin gives no false exit
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sleep_n_q_ff <= 1'b1;
        end else begin
            sleep_n_q_ff <= sleep_n_sync;
        end
    end

    assign asleep     = !sleep_n_sync;
    assign sleep_exit = sleep_n_sync && !sleep_n_q_ff;

    // io rail control, system reset domain

    logic       io_decay_en_ff;
    logic [1:0] io_mode_ff;
    logic [7:0] io_ctrl_rd;

    // only decay enable and mode are stored; the rest is wired
    always_ff @(posedge clk_in or negedge sys_rstn_in) begin
        if (!sys_rstn_in) begin
            io_decay_en_ff <= IO_RST[`RFPG_IO_DECAY_BIT];
            io_mode_ff     <= IO_RST[`RFPG_IO_MODE_HI:`RFPG_IO_MODE_LO];
        end else if (wr_io) begin
            io_decay_en_ff <= req_in.wdata[`RFPG_IO_DECAY_BIT];
            io_mode_ff     <= req_in.wdata[`RFPG_IO_MODE_HI:
                                           `RFPG_IO_MODE_LO];
        end
    end

    // reserved bits 7, 5-4, 3-2 come from the fixed pattern
    assign io_ctrl_rd = (`RFPG_IO_FIXED_VAL & `RFPG_IO_FIXED_MASK)
                      | {1'b0, io_decay_en_ff, 4'h0, io_mode_ff};

    // core rail control, system reset domain

    logic [1:0] core_lp_ff;
    logic [1:0] core_vsel_ff;
    logic [1:0] core_exit_ff;
    logic [1:0] core_mode_ff;
    logic [1:0] nxt_core_mode;
    logic       exit_reload;
    logic [7:0] core_ctrl_rd;

    // a nonzero exit field reloads the mode on wake; the hardware
    // event beats a software write landing in the same cycle
    assign exit_reload   = sleep_exit
                        && (core_exit_ff != `RFPG_EXIT_CODE_KEEP);
    assign nxt_core_mode = exit_reload ? core_exit_ff
                         : wr_core ? req_in.wdata[`RFPG_CORE_MODE_HI:
                                                  `RFPG_CORE_MODE_LO]
                         : core_mode_ff;

    always_ff @(posedge clk_in or negedge sys_rstn_in) begin
        if (!sys_rstn_in) begin
            core_lp_ff   <= `RFPG_CORE_RST_LP;
            core_vsel_ff <= `RFPG_CORE_RST_VSEL;
            core_exit_ff <= `RFPG_CORE_RST_EXIT;
            core_mode_ff <= `RFPG_CORE_RST_MODE;
        end else begin
            if (wr_core) begin
                core_lp_ff   <= req_in.wdata[`RFPG_CORE_LP_HI:
                                             `RFPG_CORE_LP_LO];
                core_vsel_ff <= req_in.wdata[`RFPG_CORE_VSEL_HI:
                                             `RFPG_CORE_VSEL_LO];
                core_exit_ff <= req_in.wdata[`RFPG_CORE_EXIT_HI:
                                             `RFPG_CORE_EXIT_LO];
            end
            core_mode_ff <= nxt_core_mode;
        end
    end

    assign core_ctrl_rd = {core_lp_ff, core_vsel_ff, core_exit_ff,
                           core_mode_ff};

    // rail requests

    logic [`RFPG_MV_W-1:0] norm_mv;
    logic [`RFPG_MV_W-1:0] lp_mv;
    logic [`RFPG_MV_W-1:0] nxt_core_mv;
    rfpg_io_req_t          nxt_io_req;
    rfpg_core_req_t        nxt_core_req;
    rfpg_io_req_t          io_req_ff;
    rfpg_core_req_t        core_req_ff;

    // normal set point table
    assign norm_mv = (core_vsel_ff == 2'h0) ? `RFPG_VSEL0_MV
                   : (core_vsel_ff == 2'h1) ? `RFPG_VSEL1_MV
                   : (core_vsel_ff == 2'h2) ? `RFPG_VSEL2_MV
                   : `RFPG_VSEL3_MV;

    // low-power set point table; code zero falls back to normal
    assign lp_mv = (core_lp_ff == 2'h1) ? `RFPG_LP1_MV
                 : (core_lp_ff == 2'h2) ? `RFPG_LP2_MV
                 : (core_lp_ff == 2'h3) ? `RFPG_LP3_MV
                 : norm_mv;

    assign nxt_core_mv = asleep ? lp_mv : norm_mv;

    // decay only when enabled and the host holds sleep low; the
    // 2 us gap after forced pwm is left to the controller software
    assign nxt_io_req.mode  = mode_of(io_mode_ff);
    assign nxt_io_req.decay = io_decay_en_ff && asleep;

    assign nxt_core_req.mode      = mode_of(core_mode_ff);
    assign nxt_core_req.target_mv = nxt_core_mv;

    // requests follow system reset so the rails see reset defaults
    always_ff @(posedge clk_in or negedge sys_rstn_in) begin
        if (!sys_rstn_in) begin
            io_req_ff   <= '{mode: RFPG_MODE_AUTO, decay: 1'b0};
            core_req_ff <= '{mode: RFPG_MODE_AUTO,
                             target_mv: `RFPG_VSEL0_MV};
        end else begin
            io_req_ff   <= nxt_io_req;
            core_req_ff <= nxt_core_req;
        end
    end

    // read path

    logic [7:0] rd_mux;
    logic [7:0] rdata_ff;

    // address decode; unmapped offsets read zero
    always_comb begin
        rd_mux = `RFPG_RST_UNMAPPED;
        if (req_in.addr == `RFPG_OFS_FAULT_A) begin
            rd_mux = fault_a_ff;
        end else if (req_in.addr == `RFPG_OFS_FAULT_B) begin
            rd_mux = {6'h00, fault_b_ff};
        end else if (req_in.addr == `RFPG_OFS_PG_MASK_A) begin
            rd_mux = mask_a_ff;
        end else if (req_in.addr == `RFPG_OFS_PG_MASK_B) begin
            rd_mux = {4'h0, mask_b_ff};
        end else if (req_in.addr == `RFPG_OFS_IO_CTRL) begin
            rd_mux = io_ctrl_rd;
        end else if (req_in.addr == `RFPG_OFS_CORE_CTRL) begin
            rd_mux = core_ctrl_rd;
        end
    end

    // read data is captured on the strobe and held until the next one
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_ff <= 8'h00;
        end else if (req_in.rd) begin
            rdata_ff <= rd_mux;
        end
    end

    // outputs, all straight from flip-flops

    assign rdata_out       = rdata_ff;
    assign pg_combined_out = pg_combined_ff;
    assign io_req_out      = io_req_ff;
    assign core_req_out    = core_req_ff;

endmodule : rfpg_regs

// File: rtl/rfpg_sync.sv
// two-flip-flop synchroniser for a vector of independent level inputs.
// assumes: each bit is a slow level; no bus coherency is needed across bits.
`timescale 1ns/1ps

module rfpg_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    // one pair of stages per bit; only the second stage is read outside
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    meta_ff[gi] <= RST_VAL[gi];
                    sync_ff[gi] <= RST_VAL[gi];
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_out = sync_ff;

endmodule : rfpg_sync

// File: sim/rfpg_ec_model.sv
// embedded controller and host sleep pin facing the bank
// assumes: bench calls the tasks; signals move 1 ns after clk_in rises
`timescale 1ns/1ps
module rfpg_ec_model
    import rfpg_pkg::*;
(
    input  wire logic clk_in,
    output rfpg_req_t req_out,
    output logic      sleep_n_out
);
    initial begin
        req_out = '0;
        sleep_n_out = 1'b1;
    end
    // one-cycle request; idle fields inverted so stale values never match
    task automatic access(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
        @(posedge clk_in);
        #1;
        req_out = {a, d, w, !w};
        @(posedge clk_in);
        #1;
        req_out = {~a, ~d, 1'b0, 1'b0};
    endtask : access
    // drop forced pwm first; going straight to decay can ring
    task automatic arm_io_decay();
        access(1'b1, 8'h30, 8'h01);
        repeat (400) @(posedge clk_in);
        access(1'b1, 8'h30, 8'h41);
    endtask : arm_io_decay
    task automatic set_sleep(input logic v);
        @(posedge clk_in);
        #1;
        sleep_n_out = v;
    endtask : set_sleep
endmodule : rfpg_ec_model

// File: sim/rfpg_regs_sva.sv
// port checker for the fault / power-good / rail control bank
// assumes: bound onto rfpg_regs; one clock, always-on reset gates all
`timescale 1ns/1ps
module rfpg_regs_sva
    import rfpg_pkg::*;
(
    input wire logic           clk_in,
    input wire logic           rstn_in,
    input wire logic           sys_rstn_in,
    input wire rfpg_req_t      req_in,
    input wire logic [7:0]     fault_a_in,
    input wire logic [1:0]     fault_b_in,
    input wire logic [7:0]     pg_a_in,
    input wire logic [3:0]     pg_b_in,
    input wire logic           host_sleep_n_in,
    input wire logic [7:0]     rdata_out,
    input wire logic           pg_combined_out,
    input wire rfpg_io_req_t   io_req_out,
    input wire rfpg_core_req_t core_req_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    // read side: fixed bits and unmapped space
    chk_unmapped_rd: assert property (req_in.rd && req_in.addr == 8'h20
        |=> rdata_out == 8'h00) else $error("unmapped read not zero");
    chk_fault_b_rsvd: assert property (req_in.rd && req_in.addr == 8'h17
        |=> rdata_out[7:2] == 6'h00) else $error("fault b high bits set");
    chk_mask_b_rsvd: assert property (req_in.rd && req_in.addr == 8'h19
        |=> rdata_out[7:4] == 4'h0) else $error("mask b high bits set");
    chk_io_fixed: assert property (req_in.rd && req_in.addr == 8'h30
        |=> (rdata_out & 8'hbc) == 8'h18) else $error("io fixed bits wrong");
    // pins: synchroniser depth plus one output flop; system reset acts at once
    chk_pg_all_good: assert property ((&pg_a_in && &pg_b_in) [*4]
        |-> pg_combined_out) else $error("pg low with all inputs good");
    chk_fault_sticky: assert property (fault_a_in[7] [*4] ##0
        (req_in.rd && req_in.addr == 8'h16) |=> rdata_out[7])
        else $error("io fault flag not set");
    chk_decay_asleep: assert property (
        disable iff (!sys_rstn_in || !rstn_in)
        io_req_out.decay |-> $past(!host_sleep_n_in, 3))
        else $error("decay without sleep");
    chk_sys_rst_core: assert property (!sys_rstn_in |->
        core_req_out.mode == RFPG_MODE_AUTO &&
        core_req_out.target_mv == 10'h3b6)
        else $error("core request not at reset value");
endmodule : rfpg_regs_sva

bind rfpg_regs rfpg_regs_sva rfpg_regs_sva_i (.clk_in(clk_in),
    .rstn_in(rstn_in), .sys_rstn_in(sys_rstn_in), .req_in(req_in),
    .fault_a_in(fault_a_in), .fault_b_in(fault_b_in), .pg_a_in(pg_a_in),
    .pg_b_in(pg_b_in), .host_sleep_n_in(host_sleep_n_in),
    .rdata_out(rdata_out), .pg_combined_out(pg_combined_out),
    .io_req_out(io_req_out), .core_req_out(core_req_out));

// File: sim/rfpg_regs_tb_top.sv
// self-checking bench for the rail fault / pg / control bank
// assumes: rfpg_ec_model drives requests and the sleep pin
`timescale 1ns/1ps
module rfpg_regs_tb_top
    import rfpg_pkg::*;
;
    typedef struct packed {logic w; logic [7:0] a, d, e;} rfpg_row_t;
    logic           clk_in, rstn_in, sys_rstn_in, slp_n, pg_c;
    logic [7:0]     fa, pga, rdata;
    logic [1:0]     fb;
    logic [3:0]     pgb;
    rfpg_req_t      req;
    rfpg_io_req_t   io_req;
    rfpg_core_req_t core_req;
    int             bad_count, total_checks, cyc, i;
    rfpg_mode_t     me [4] = '{RFPG_MODE_OFF, RFPG_MODE_AUTO,
                               RFPG_MODE_AUTO, RFPG_MODE_FORCED};
    logic [9:0]     mv [4] = '{10'h3b6, 10'h384, 10'h352, 10'h320};
    rfpg_row_t      rows [13] = '{
        {1'b0, 8'h16, 8'h00, 8'h00}, {1'b0, 8'h17, 8'h00, 8'h00},
        {1'b0, 8'h18, 8'h00, 8'h00}, {1'b0, 8'h19, 8'h00, 8'h00},
        {1'b0, 8'h30, 8'h00, 8'h1a}, {1'b0, 8'h31, 8'h00, 8'h4a},
        {1'b1, 8'h18, 8'hff, 8'hff}, {1'b1, 8'h19, 8'hff, 8'h0f},
        {1'b1, 8'h17, 8'hff, 8'h00}, {1'b1, 8'h16, 8'hff, 8'h00},
        {1'b1, 8'h30, 8'hff, 8'h5b}, {1'b1, 8'h31, 8'ha5, 8'ha5},
        {1'b1, 8'h20, 8'hff, 8'h00}};

    rfpg_ec_model rfpg_ec_model_i (.clk_in(clk_in), .req_out(req),
        .sleep_n_out(slp_n));
    rfpg_regs rfpg_regs_i (.clk_in(clk_in), .rstn_in(rstn_in),
        .sys_rstn_in(sys_rstn_in), .req_in(req), .fault_a_in(fa),
        .fault_b_in(fb), .pg_a_in(pga), .pg_b_in(pgb),
        .host_sleep_n_in(slp_n), .rdata_out(rdata), .pg_combined_out(pg_c),
        .io_req_out(io_req), .core_req_out(core_req));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rfpg_ec_model_i.access(1'b1, a, d);
    endtask : wr
    // read data is registered, settled when the access returns
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rfpg_ec_model_i.access(1'b0, a, 8'h00);
        chk({4'h0, rdata}, {4'h0, e});
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    end

    initial begin
        {rstn_in, sys_rstn_in, fa, fb} = '0;
        pga = 8'hff;
        pgb = 4'hf;
        tick(16);
        {rstn_in, sys_rstn_in} = 2'b11;
        foreach (rows[k]) begin
            if (rows[k].w) wr(rows[k].a, rows[k].d);
            rd_chk(rows[k].a, rows[k].e);
        end
        $display("register table done");
        wr(8'h18, 8'h00);
        wr(8'h19, 8'h00);
        tick(1);
        chk({11'h0, pg_c}, 12'h001);
        pga = 8'hbf;
        tick(3);
        chk({11'h0, pg_c}, 12'h000);
        wr(8'h18, 8'h40);
        tick(1);
        chk({11'h0, pg_c}, 12'h001);
        pgb = 4'h7;
        tick(3);
        chk({11'h0, pg_c}, 12'h000);
        wr(8'h19, 8'h08);
        tick(1);
        chk({11'h0, pg_c}, 12'h001);
        $display("pg tree done");
        {fa, fb} = {8'h81, 2'h3};
        tick(4);
        rd_chk(8'h16, 8'h81);
        rd_chk(8'h17, 8'h03);
        {fa, fb} = '0;
        tick(3);
        rd_chk(8'h16, 8'h81);
        wr(8'h16, 8'h7f);
        rd_chk(8'h16, 8'h01);
        wr(8'h17, 8'h00);
        rd_chk(8'h17, 8'h00);
        $display("fault flags done");
        for (i = 0; i < 4; i++) begin
            wr(8'h31, {2'h0, i[1:0], 2'h0, i[1:0]});
            tick(1);
            chk(core_req, {me[i], mv[i]});
        end
        $display("mode and select done");
        rfpg_ec_model_i.arm_io_decay();
        wr(8'h31, 8'h8d);
        tick(1);
        chk({9'h0, io_req}, {9'h0, RFPG_MODE_AUTO, 1'b0});
        rfpg_ec_model_i.set_sleep(1'b0);
        tick(3);
        chk(core_req, {RFPG_MODE_AUTO, 10'h320});
        chk({11'h0, io_req.decay}, 12'h001);
        rfpg_ec_model_i.set_sleep(1'b1);
        tick(4);
        chk(core_req, {RFPG_MODE_FORCED, 10'h3b6});
        chk({11'h0, io_req.decay}, 12'h000);
        rd_chk(8'h31, 8'h8f);
        $display("sleep and wake done");
        sys_rstn_in = 1'b0;
        tick(1);
        chk(core_req, {RFPG_MODE_AUTO, 10'h3b6});
        sys_rstn_in = 1'b1;
        rd_chk(8'h30, 8'h1a);
        rd_chk(8'h18, 8'h40);
        $display("system reset done");
        wr(8'h31, 8'h03);
        rfpg_ec_model_i.set_sleep(1'b0);
        tick(3);
        chk(core_req, {RFPG_MODE_FORCED, 10'h3b6});
        chk({11'h0, io_req.decay}, 12'h000);
        rfpg_ec_model_i.set_sleep(1'b1);
        tick(4);
        rd_chk(8'h31, 8'h03);
        $display("exit keep done");
        stop_test();
    end
endmodule : rfpg_regs_tb_top
